// ---- apcr_pkg.sv ----
// package: page ids, register offsets, field positions and reset values
package apcr_pkg;
   // page identifiers
   localparam logic [15:0] PAGE_MASTER  = 16'h0080;
   localparam logic [15:0] PAGE_ADC     = 16'h000F;
   localparam logic [15:0] PAGE_DIGITAL = 16'h6800;
   // register offsets within pages
   localparam logic [7:0] OFF_APPLY_STROBE  = 8'h00;
   localparam logic [7:0] OFF_IL_MODE       = 8'h40;
   localparam logic [7:0] OFF_IL_OVERRIDE   = 8'h4E;
   localparam logic [7:0] OFF_POWER_DOWN    = 8'h55;
   localparam logic [7:0] OFF_OVR_ROUTING   = 8'h59;
   localparam logic [7:0] OFF_OVR_THRESHOLD = 8'h5F;
   // field positions
   localparam int BIT_APPLY       = 0;
   localparam int BIT_PDN_EN      = 4;
   localparam int BIT_ROUTE_CHB   = 7;
   localparam int BIT_ALWAYS_ONE  = 5;
   localparam int BIT_IL_OVERRIDE = 0;
   // interleave mode encodings
   localparam logic [7:0] IL_MODE_ENABLED  = 8'h00;
   localparam logic [7:0] IL_MODE_DISABLED = 8'h08;
   // reset values
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [7:0] RST_THRESHOLD = 8'h00;
   localparam int         NUM_DIG       = 2;  // shadowed bytes: mode, override

   // one register access from the serial control interface
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] page;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } apcr_req_t;

   // settings presented to the rest of the device
   typedef struct packed {
      logic       register_power_down_enable;
      logic       chan_b_overrange_routing;
      logic [7:0] overrange_threshold_setting;
      logic       interleave_engine_on;
   } apcr_cfg_t;
endpackage : apcr_pkg

// ---- apcr_shadow.sv ----
// file: shadow and active copies of main digital page settings
`timescale 1ns/1ps
module apcr_shadow #(
   parameter int NUM = 3
) (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               wr_en,
   input  wire logic [1:0]         wr_idx,
   input  wire logic [7:0]         wr_data,
   input  wire logic               commit,
   output logic      [NUM*8-1:0]   active_q
);
   typedef struct packed {
      logic [NUM*8-1:0] shadow;
      logic [NUM*8-1:0] active;
   } apcr_sh_state_t;

   apcr_sh_state_t s_q, s_d;

   // writes land in shadow; commit copies shadow to active
   always_comb begin
      s_d = s_q;
      for (int i = 0; i < NUM; i++) begin
         if (wr_en && wr_idx == 2'(i)) begin
            s_d.shadow[i*8 +: 8] = wr_data;
         end
      end
      if (commit) begin
         s_d.active = s_d.shadow;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign active_q = s_q.active;
endmodule : apcr_shadow

// ---- apcr_regs.sv ----
// file: paged configuration register bank of a dual-channel converter
`timescale 1ns/1ps
module apcr_regs (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire apcr_pkg::apcr_req_t req,
   input  wire logic                serial_data_out_normal,
   input  wire logic                fast_overrange_flag_b,
   output logic                     rdata_valid,
   output logic [7:0]               rdata,
   output apcr_pkg::apcr_cfg_t      cfg,
   output logic                     serial_data_out_pin
);
   ////////////////////////////////////////////////////////////////////////////
   // timing at the ports, all on the rising edge of sys_clk:
   // a request counts on the edge where req.wr or req.rd is high;
   // read data and its valid strobe stand for the next cycle only;
   // master and adc page settings reach cfg two edges after the write;
   // main digital page settings reach cfg two edges after the commit;
   // unmapped places drop writes and read back as zero;
   // after reset every output is low except the engine-on flag;
   // back-to-back requests are fine, there is no busy state

   // all state of the bank except the shadowed bytes (held in u_shadow) in one record
   typedef struct packed {
      logic                pdn;         // power-down enable bit
      logic                route;       // write-only chan b routing bit
      logic                always_one;  // readable must-be-one bit
      logic [7:0]          thr;         // shared overrange threshold
      logic                apply;       // last written apply bit
      logic                rvalid;      // read answer strobe
      logic [7:0]          rdata;       // read answer byte
      apcr_pkg::apcr_cfg_t cfg;         // settings seen by the device
      logic                pin_out;     // registered output pin level
   } apcr_state_t;

   apcr_state_t s_q;
   apcr_state_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // decode page plus offset into one hit; shared by every register
   function automatic logic hit(
      input logic [15:0] pg,
      input logic [7:0]  ad,
      input logic [15:0] want_pg,
      input logic [7:0]  want_ad
   );
      hit = (pg == want_pg) && (ad == want_ad);
   endfunction : hit

   // engine state from the committed mode and override bytes;
   // reserved codes leave the engine running, the safer default
   function automatic logic engine_on(
      input logic [7:0] mode,
      input logic [7:0] ovr_byte
   );
      if (ovr_byte[apcr_pkg::BIT_IL_OVERRIDE]) begin
         engine_on = (mode != apcr_pkg::IL_MODE_DISABLED);
      end else begin
         engine_on = 1'h1;
      end
   endfunction : engine_on

   ////////////////////////////////////////////////////////////////////////////
   // register hits
   logic h_pdn;
   logic h_rt;
   logic h_thr;
   logic h_app;
   logic h_il;
   logic h_ov;

   // page selection
   // master page: power-down and routing
   assign h_pdn = hit(req.page, req.addr, apcr_pkg::PAGE_MASTER,  apcr_pkg::OFF_POWER_DOWN);
   assign h_rt  = hit(req.page, req.addr, apcr_pkg::PAGE_MASTER,  apcr_pkg::OFF_OVR_ROUTING);
   // adc page: shared threshold
   assign h_thr = hit(req.page, req.addr, apcr_pkg::PAGE_ADC,     apcr_pkg::OFF_OVR_THRESHOLD);
   // main digital page: apply strobe, mode, override
   assign h_app = hit(req.page, req.addr, apcr_pkg::PAGE_DIGITAL, apcr_pkg::OFF_APPLY_STROBE);
   assign h_il  = hit(req.page, req.addr, apcr_pkg::PAGE_DIGITAL, apcr_pkg::OFF_IL_MODE);
   assign h_ov  = hit(req.page, req.addr, apcr_pkg::PAGE_DIGITAL, apcr_pkg::OFF_IL_OVERRIDE);

   ////////////////////////////////////////////////////////////////////////////
   // main digital page shadow
   // slot 0 holds the mode byte, slot 1 the override byte
   logic                           sh_wr;
   logic [1:0]                     sh_idx;
   logic                           commit;
   logic [apcr_pkg::NUM_DIG*8-1:0] active;
   logic [7:0]                     active_mode;
   logic [7:0]                     active_override;

   // mode and override writes go to the shadow only
   always_comb begin
      sh_wr = req.wr && (h_il || h_ov);
      if (h_il) begin
         sh_idx = 2'h0;
      end else begin
         sh_idx = 2'h1;
      end
   end

   // commit closes the low-high-low apply pulse
   // a lone write of 0 after reset does not commit, so a half-written
   // shadow never leaks into the engine before software asks for it
   assign commit = s_q.apply && req.wr && h_app && !req.wdata[apcr_pkg::BIT_APPLY];

   // shadow holds pending bytes; active is what the device uses
   apcr_shadow #(
      .NUM (apcr_pkg::NUM_DIG)
   ) u_shadow (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .wr_en    (sh_wr),
      .wr_idx   (sh_idx),
      .wr_data  (req.wdata),
      .commit   (commit),
      .active_q (active)
   );

   // byte lanes of the committed copy
   assign active_mode     = active[7:0];
   assign active_override = active[15:8];

   ////////////////////////////////////////////////////////////////////////////
   // next state: writes, readback and output staging
   always_comb begin
      s_d = s_q;
      // a read is answered exactly one cycle later
      s_d.rvalid = req.rd;

      // register writes; reserved bits are dropped, not stored
      if (req.wr) begin
         if (h_pdn) begin
            s_d.pdn = req.wdata[apcr_pkg::BIT_PDN_EN];
         end
         if (h_rt) begin
            s_d.route      = req.wdata[apcr_pkg::BIT_ROUTE_CHB];
            s_d.always_one = req.wdata[apcr_pkg::BIT_ALWAYS_ONE];
         end
         if (h_thr) begin
            s_d.thr = req.wdata;
         end
         if (h_app) begin
            s_d.apply = req.wdata[apcr_pkg::BIT_APPLY];
         end
      end

      // readback; write-only fields and unmapped places read as zero
      s_d.rdata = apcr_pkg::RST_BYTE;
      if (req.rd) begin
         // power-down byte shows only its enable bit
         if (h_pdn) begin
            s_d.rdata[apcr_pkg::BIT_PDN_EN] = s_q.pdn;
         end
         // routing byte hides the write-only routing bit
         if (h_rt) begin
            s_d.rdata[apcr_pkg::BIT_ALWAYS_ONE] = s_q.always_one;
         end
         // threshold reads back whole
         if (h_thr) begin
            s_d.rdata = s_q.thr;
         end
         // apply bit reads back as last written
         if (h_app) begin
            s_d.rdata[apcr_pkg::BIT_APPLY] = s_q.apply;
         end
      end

      s_d.cfg.register_power_down_enable = s_q.pdn;
      // routing select reported in cfg; the pin uses the stored bit
      s_d.cfg.chan_b_overrange_routing = s_q.route;
      s_d.cfg.overrange_threshold_setting = s_q.thr;
      s_d.cfg.interleave_engine_on = engine_on(active_mode, active_override);

      // output pin mux, registered so the pin never glitches
      // the select is the stored bit, one cycle ahead of cfg
      if (s_q.route) begin
         s_d.pin_out = fast_overrange_flag_b;
      end else begin
         s_d.pin_out = serial_data_out_normal;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronous reset; engine starts enabled since mode 0 means on
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q                                 <= '0;
         s_q.thr                             <= apcr_pkg::RST_THRESHOLD;
         s_q.cfg.overrange_threshold_setting <= apcr_pkg::RST_THRESHOLD;
         s_q.cfg.interleave_engine_on        <= 1'h1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // every output comes straight from a flop of the state record
   assign rdata_valid         = s_q.rvalid;
   assign rdata               = s_q.rdata;
   assign cfg                 = s_q.cfg;
   assign serial_data_out_pin = s_q.pin_out;
endmodule : apcr_regs

// ---- apcr_regs_checker.sv ----
// checker: port timing of the paged register bank
`timescale 1ns/1ps
module apcr_regs_checker (
   input wire logic                sys_clk,
   input wire logic                rst,
   input wire apcr_pkg::apcr_req_t req,
   input wire logic                serial_data_out_normal,
   input wire logic                fast_overrange_flag_b,
   input wire logic                rdata_valid,
   input wire logic [7:0]          rdata,
   input wire apcr_pkg::apcr_cfg_t cfg,
   input wire logic                serial_data_out_pin
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // decoded accesses
   wire pm  = req.page == apcr_pkg::PAGE_MASTER;
   wire pa  = req.page == apcr_pkg::PAGE_ADC;
   wire pd  = req.page == apcr_pkg::PAGE_DIGITAL;
   wire w55 = req.wr && pm && req.addr == apcr_pkg::OFF_POWER_DOWN;
   wire w59 = req.wr && pm && req.addr == apcr_pkg::OFF_OVR_ROUTING;
   wire w5f = req.wr && pa && req.addr == apcr_pkg::OFF_OVR_THRESHOLD;
   wire cmt = req.wr && pd && req.addr == apcr_pkg::OFF_APPLY_STROBE && !req.wdata[0];
   wire rt  = cfg.chan_b_overrange_routing;
   property p_rd; req.rd |=> rdata_valid; endproperty
   a_rd: assert property (p_rd) else $error("no read answer");
   property p_nrd; !req.rd |=> !rdata_valid; endproperty
   a_nrd: assert property (p_nrd) else $error("stray read answer");
   property p_pdn; w55 |-> ##2 cfg.register_power_down_enable == $past(req.wdata[4], 2); endproperty
   a_pdn: assert property (p_pdn) else $error("power-down bit wrong");
   property p_rt; w59 |-> ##2 rt == $past(req.wdata[7], 2); endproperty
   a_rt: assert property (p_rt) else $error("routing bit wrong");
   property p_th; w5f |-> ##2 cfg.overrange_threshold_setting == $past(req.wdata, 2); endproperty
   a_th: assert property (p_th) else $error("threshold wrong");
   // select must be settled so either copy of it gives the same choice
   property p_pin;
      rt == $past(rt) && !$past(rst)
         |-> serial_data_out_pin ==
             (rt ? $past(fast_overrange_flag_b) : $past(serial_data_out_normal));
   endproperty
   a_pin: assert property (p_pin) else $error("output pin mux wrong");
   property p_ie; $changed(cfg.interleave_engine_on) |-> $past(cmt, 2); endproperty
   a_ie: assert property (p_ie) else $error("engine changed without apply");
   property p_bad; req.rd && !pm && !pa && !pd |=> rdata == 8'h00; endproperty
   a_bad: assert property (p_bad) else $error("unmapped read not zero");
   c_ie: cover property (cmt ##2 $changed(cfg.interleave_engine_on));
   c_rt: cover property (w59 && req.wdata[7]);
   c_bad: cover property (req.rd && !pm && !pa && !pd);
endmodule : apcr_regs_checker
bind apcr_regs apcr_regs_checker u_apcr_regs_checker (.sys_clk, .rst, .req, .serial_data_out_normal,
   .fast_overrange_flag_b, .rdata_valid, .rdata, .cfg, .serial_data_out_pin);

// ---- apcr_regs_bench.sv ----
// bench: directed scenarios for the paged register bank
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: mismatch", $time); end end
module apcr_regs_bench;
   localparam logic [15:0] M = apcr_pkg::PAGE_MASTER;
   localparam logic [15:0] A = apcr_pkg::PAGE_ADC;
   localparam logic [15:0] D = apcr_pkg::PAGE_DIGITAL;
   logic                sys_clk = 1'b0;
   logic                rst = 1'b1;
   apcr_pkg::apcr_req_t req = '0;
   logic                serial_data_out_normal = 1'b0;
   logic                fast_overrange_flag_b = 1'b0;
   logic                rdata_valid;
   logic [7:0]          rdata;
   apcr_pkg::apcr_cfg_t cfg;
   logic                serial_data_out_pin;
   int                  fail_count = 0;
   int                  total_checks = 0;
   apcr_regs u_apcr_regs (.sys_clk, .rst, .req, .serial_data_out_normal,
      .fast_overrange_flag_b, .rdata_valid, .rdata, .cfg, .serial_data_out_pin);
   initial forever #50 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////////
   // idle cycle after each access keeps one assignment per time step
   task automatic wr(input logic [15:0] p, input logic [7:0] a, input logic [7:0] d);
      req = '{1'b1, 1'b0, p, a, d};
      @(negedge sys_clk);
      req = '0;
      @(negedge sys_clk);
   endtask : wr
   task automatic rd(input logic [15:0] p, input logic [7:0] a, input logic [7:0] e);
      req = '{1'b0, 1'b1, p, a, 8'h00};
      @(negedge sys_clk);
      `CHK(rdata_valid, 1'b1)
      `CHK(rdata, e)
      req = '0;
      @(negedge sys_clk);
   endtask : rd
   task automatic strobe;
      wr(D, 8'h00, 8'h00);
      wr(D, 8'h00, 8'h01);
      wr(D, 8'h00, 8'h00);
   endtask : strobe
   task automatic t_pdn;
      `CHK(cfg, 11'h001)
      wr(M, 8'h55, 8'h10);
      `CHK(cfg.register_power_down_enable, 1'b1)
      rd(M, 8'h55, 8'h10);
      wr(A, 8'h55, 8'h00);
      `CHK(cfg.register_power_down_enable, 1'b1)
      wr(M, 8'h55, 8'h00);
      `CHK(cfg.register_power_down_enable, 1'b0)
   endtask : t_pdn
   task automatic t_route;
      fast_overrange_flag_b = 1'b1;
      wr(M, 8'h59, 8'hA0);
      @(negedge sys_clk);
      `CHK(serial_data_out_pin, 1'b1)
      rd(M, 8'h59, 8'h20);
      fast_overrange_flag_b = 1'b0;
      @(negedge sys_clk);
      `CHK(serial_data_out_pin, 1'b0)
      serial_data_out_normal = 1'b1;
      wr(M, 8'h59, 8'h20);
      @(negedge sys_clk);
      `CHK(serial_data_out_pin, 1'b1)
   endtask : t_route
   task automatic t_thr_bad;
      wr(A, 8'h5F, 8'hA5);
      `CHK(cfg.overrange_threshold_setting, 8'hA5)
      rd(A, 8'h5F, 8'hA5);
      rd(16'h1234, 8'h55, 8'h00);
      wr(16'h1234, 8'h55, 8'h10);
      `CHK(cfg.register_power_down_enable, 1'b0)
   endtask : t_thr_bad
   task automatic t_il;
      wr(D, 8'h40, 8'h08);
      rd(D, 8'h40, 8'h00);
      strobe();
      `CHK(cfg.interleave_engine_on, 1'b1)
      wr(D, 8'h4E, 8'h01);
      wr(D, 8'h40, 8'h08);
      `CHK(cfg.interleave_engine_on, 1'b1)
      strobe();
      `CHK(cfg.interleave_engine_on, 1'b0)
      wr(D, 8'h40, 8'h00);
      strobe();
      `CHK(cfg.interleave_engine_on, 1'b1)
   endtask : t_il
   task automatic stop_test;
      if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      t_pdn();
      t_route();
      t_thr_bad();
      t_il();
      stop_test();
   end
   // watchdog far beyond the sixty or so cycles needed
   initial begin
      #1ms;
      fail_count++;
      stop_test();
   end
endmodule : apcr_regs_bench
